// ==== core/trbmsa_core.sv ====
// trbmsa_core: execution of table reads, carry bit moves and skip adds for a
// 4-bit core, with its nibble registers, carry flag, counter and skip state.
// assumes: one operation offered at a time with a valid/ready handshake;
// program and data memory answer one cycle after their read strobe.
`timescale 1ns/10ps
`include "trbmsa_cfg.svh"

// Function
// - pointer table read: address is counter page bits then second pointer pair.
// - accumulator table read: address is counter page bits then wide accumulator pair.
// - table byte low nibble goes to accumulator, high nibble to upper register.
// - page bits come from the counter value while the table read executes.
// - pointer table read at last page byte uses the following page.
// - accumulator table read at last page byte also uses the following page.
// - table reads only advance the counter normally, nothing else.
// - short register table address is B bit 0, then C, X, A.
// - long register table address is B low three bits, then C, D, E.
// - counter is 13 bits by default, 12 or 14 in variants.
// - bit-to-carry move copies a data bit chosen by three addressing forms.
// - carry-to-bit move writes carry into one bit, other bits kept.
// - nibble immediate add skips next on carry out, carry flag untouched.
// - byte immediate add to wide pair skips on bit seven carry out.
// - memory nibble add through pointer pair skips on carry, carry untouched.
// - any selectable pair added to wide pair skips on carry, carry untouched.
// - nibble skip add after carry add or subtract on memory converts number base.
// - no carry or a borrow runs it with skip suppressed; otherwise skipped.
module trbmsa_core #(
  parameter int PC_W = `TRBMSA_PC_W,
  parameter int DA_W = `TRBMSA_DA_W
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_op_valid,
  output logic o_op_ready,
  input wire trbmsa_pkg::trbmsa_op_e i_op,
  input wire logic [1:0] i_op_len,
  input wire logic [7:0] i_imm,
  input wire logic [2:0] i_pair_sel,
  input wire trbmsa_pkg::trbmsa_bit_mode_e i_bit_mode,
  input wire logic [7:0] i_mem_addr,
  input wire logic [1:0] i_bit_sel,
  input wire logic [3:0] i_mem_bank,
  output logic o_op_done,
  output logic o_op_skipped,
  output logic o_skip_pending,
  input wire logic i_reg_wr,
  input wire logic [3:0] i_reg_idx,
  input wire logic [3:0] i_reg_wdata,
  input wire logic i_cy_wr,
  input wire logic i_cy_wdata,
  input wire logic i_pc_wr,
  input wire logic [PC_W-1:0] i_pc_wdata,
  output logic [PC_W-1:0] o_pc,
  output logic o_carry_flag,
  output logic [7:0] o_wide_accumulator_pair,
  output logic [7:0] o_memory_pointer_pair,
  output logic [7:0] o_pointer_pair_two,
  output logic [7:0] o_general_pair_three,
  output logic o_pmem_rd,
  output logic [PC_W-1:0] o_pmem_addr,
  input wire logic [7:0] i_pmem_rdata,
  output logic o_dmem_rd,
  output logic o_dmem_wr,
  output logic [DA_W-1:0] o_dmem_addr,
  output logic [3:0] o_dmem_wdata,
  input wire logic [3:0] i_dmem_rdata
);
  import trbmsa_pkg::*;

  trbmsa_state_e state_r, state_nxt;
  trbmsa_op_e op_r;
  logic [3:0] regs_r [`TRBMSA_NUM_NIB];
  logic [7:0] pair_w [`TRBMSA_NUM_PAIR];
  logic [PC_W-1:0] pc_r, pc_inc, pc_adv, tbl_addr;
  logic [PC_W-1:0] pmem_addr_r;
  logic [DA_W-1:0] dmem_addr_r;
  logic [1:0] bit_r;
  logic [3:0] wdata_r;
  logic carry_flag_r, skip_r, conv_pend_r, conv_skip_r, done_r, skipped_r;
  logic take, conv_hit, eff_skip, exec_now, pcap, dcap;
  logic [3:0] reg_a, reg_x, reg_h, reg_l;
  logic [4:0] sum_a_imm, sum_a_mem, sum_a_adc, dif_a_sbc;
  logic [8:0] sum_xa_imm, sum_xa_pair;
  logic [DA_W+1:0] bit_tgt;
  logic [3:0] bit_merged;
  logic a_we, x_we, cy_we, cy_val, skip_val;
  logic [3:0] a_wv, x_wv;
  logic is_tbl, is_dmem, is_single;

  // bit-manipulation decode: {data address, bit number}
  function automatic logic [DA_W+1:0] bit_target(input trbmsa_bit_mode_e mode,
      input logic [7:0] maddr, input logic [1:0] bsel, input logic [3:0] bank,
      input logic [3:0] h, input logic [3:0] l);
    logic [DA_W+1:0] t;
    t = '0;
    case (mode)
      BIT_FIXED_SPACE: t = {DA_W'({`TRBMSA_FIX_BANK, maddr}), bsel};
      // pointer-low picks the nibble in the upper 2 bits, bit in the lower 2
      BIT_PERIPHERAL_AT_LOW: t = {DA_W'({`TRBMSA_FIX_BANK, maddr[7:2], l[3:2]}), l[1:0]};
      BIT_HIGH_PLUS_OFFSET: t = {DA_W'({bank, h, maddr[3:0]}), bsel};
      default: t = '0;
    endcase
    return t;
  endfunction

  // pairs laid out as {odd slot, even slot}: XA, HL, DE, BC, then alternates
  for (genvar p = 0; p < `TRBMSA_NUM_PAIR; p++) begin : g_pair
    assign pair_w[p] = {regs_r[2*p+1], regs_r[2*p]};
  end

  assign reg_a = regs_r[`TRBMSA_IDX_A];
  assign reg_x = regs_r[`TRBMSA_IDX_X];
  assign reg_h = regs_r[`TRBMSA_IDX_H];
  assign reg_l = regs_r[`TRBMSA_IDX_L];

  // handshake and skip decisions
  assign take = i_op_valid && (state_r == ST_IDLE);
  assign conv_hit = conv_pend_r && (i_op == OP_SKIP_ADD_NIBBLE_IMM);
  assign eff_skip = skip_r || (conv_hit && conv_skip_r);
  assign exec_now = take && !eff_skip;
  assign pcap = (state_r == ST_PCAP);
  assign dcap = (state_r == ST_DCAP);

  // operation classes
  assign is_tbl = (i_op == OP_TABLE_READ_PAGE_PLUS_POINTER) ||
                  (i_op == OP_TABLE_READ_PAGE_PLUS_ACCUMULATOR) ||
                  (i_op == OP_TABLE_READ_REGISTER_ADDRESS_SHORT) ||
                  (i_op == OP_TABLE_READ_REGISTER_ADDRESS_LONG);
  assign is_dmem = (i_op == OP_BIT_MOVE_TO_CARRY) || (i_op == OP_BIT_MOVE_FROM_CARRY) ||
                   (i_op == OP_SKIP_ADD_MEMORY) || (i_op == OP_ADD_WITH_CARRY_MEMORY) ||
                   (i_op == OP_SUBTRACT_WITH_CARRY_MEMORY);
  assign is_single = !is_tbl && !is_dmem;

  // counter: page bits taken after the fetch increment, so an op at the
  // last byte of a page reads from the next page
  assign pc_inc = pc_r + PC_W'(1);
  assign pc_adv = pc_r + PC_W'(i_op_len);

  // table address per form; upper bits scale with PC_W
  assign tbl_addr =
    (i_op == OP_TABLE_READ_PAGE_PLUS_POINTER) ?
      {pc_inc[PC_W-1:`TRBMSA_PAGE_LSB], pair_w[2]} :
    (i_op == OP_TABLE_READ_PAGE_PLUS_ACCUMULATOR) ?
      {pc_inc[PC_W-1:`TRBMSA_PAGE_LSB], pair_w[0]} :
    (i_op == OP_TABLE_READ_REGISTER_ADDRESS_SHORT) ?
      PC_W'({regs_r[`TRBMSA_IDX_B][0], regs_r[`TRBMSA_IDX_C], reg_x, reg_a}) :
      PC_W'({regs_r[`TRBMSA_IDX_B][2:0], regs_r[`TRBMSA_IDX_C],
             regs_r[`TRBMSA_IDX_D], regs_r[`TRBMSA_IDX_E]});

  // arithmetic; the skip adds never touch the carry flag
  assign sum_a_imm = {1'b0, reg_a} + {1'b0, i_imm[3:0]};
  assign sum_xa_imm = {1'b0, pair_w[0]} + {1'b0, i_imm};
  assign sum_xa_pair = {1'b0, pair_w[0]} + {1'b0, pair_w[i_pair_sel]};
  assign sum_a_mem = {1'b0, reg_a} + {1'b0, i_dmem_rdata};
  assign sum_a_adc = {1'b0, reg_a} + {1'b0, i_dmem_rdata} + {4'h0, carry_flag_r};
  assign dif_a_sbc = {1'b0, reg_a} - {1'b0, i_dmem_rdata} - {4'h0, carry_flag_r};

  // data address: bit forms use the decode, nibble ops use the pointer pair
  assign bit_tgt = bit_target(i_bit_mode, i_mem_addr, i_bit_sel, i_mem_bank, reg_h, reg_l);
  // read-modify-write keeps the neighbour bits of the nibble
  assign bit_merged = (i_dmem_rdata & ~(4'h1 << bit_r)) |
                      ({3'h0, carry_flag_r} << bit_r);

  // accumulator writes: immediate/pair at take, table byte, memory result
  assign a_we = (exec_now && ((i_op == OP_SKIP_ADD_NIBBLE_IMM) ||
                (i_op == OP_SKIP_ADD_BYTE_IMM) || (i_op == OP_SKIP_ADD_PAIR))) || pcap ||
                (dcap && ((op_r == OP_SKIP_ADD_MEMORY) || (op_r == OP_ADD_WITH_CARRY_MEMORY) ||
                (op_r == OP_SUBTRACT_WITH_CARRY_MEMORY)));
  assign a_wv = pcap ? i_pmem_rdata[3:0] :
                dcap ? ((op_r == OP_SKIP_ADD_MEMORY) ? sum_a_mem[3:0] :
                        (op_r == OP_ADD_WITH_CARRY_MEMORY) ? sum_a_adc[3:0] : dif_a_sbc[3:0]) :
                (i_op == OP_SKIP_ADD_NIBBLE_IMM) ? sum_a_imm[3:0] :
                (i_op == OP_SKIP_ADD_BYTE_IMM) ? sum_xa_imm[3:0] : sum_xa_pair[3:0];
  assign x_we = (exec_now && ((i_op == OP_SKIP_ADD_BYTE_IMM) || (i_op == OP_SKIP_ADD_PAIR))) ||
                pcap;
  assign x_wv = pcap ? i_pmem_rdata[7:4] :
                (i_op == OP_SKIP_ADD_BYTE_IMM) ? sum_xa_imm[7:4] : sum_xa_pair[7:4];

  // carry flag: bit-to-carry move and the carry add/subtract only
  assign cy_we = dcap && ((op_r == OP_BIT_MOVE_TO_CARRY) ||
                 (op_r == OP_ADD_WITH_CARRY_MEMORY) || (op_r == OP_SUBTRACT_WITH_CARRY_MEMORY));
  assign cy_val = (op_r == OP_BIT_MOVE_TO_CARRY) ? i_dmem_rdata[bit_r] :
                  (op_r == OP_ADD_WITH_CARRY_MEMORY) ? sum_a_adc[4] : dif_a_sbc[4];

  // skip request raised by the op just taken; suppressed in base conversion
  assign skip_val = (i_op == OP_SKIP_ADD_NIBBLE_IMM) ? (sum_a_imm[4] && !conv_hit) :
                    (i_op == OP_SKIP_ADD_BYTE_IMM) ? sum_xa_imm[8] :
                    (i_op == OP_SKIP_ADD_PAIR) ? sum_xa_pair[8] : 1'b0;

  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (exec_now && is_tbl) begin
          state_nxt = ST_PREQ;
        end else if (exec_now && is_dmem) begin
          state_nxt = ST_DREQ;
        end
      end
      ST_PREQ: state_nxt = ST_PCAP;
      ST_PCAP: state_nxt = ST_IDLE;
      ST_DREQ: state_nxt = ST_DCAP;
      ST_DCAP: state_nxt = (op_r == OP_BIT_MOVE_FROM_CARRY) ? ST_DWR : ST_IDLE;
      ST_DWR: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // operand capture at take; addresses held for the memory phases
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      op_r <= OP_OTHER;
      pmem_addr_r <= '0;
      dmem_addr_r <= '0;
      bit_r <= 2'h0;
    end else if (exec_now) begin
      op_r <= i_op;
      pmem_addr_r <= tbl_addr;
      dmem_addr_r <= (i_op == OP_BIT_MOVE_TO_CARRY || i_op == OP_BIT_MOVE_FROM_CARRY) ?
                     bit_tgt[DA_W+1:2] : DA_W'({i_mem_bank, reg_h, reg_l});
      bit_r <= bit_tgt[1:0];
    end
  end

  // nibble registers; engine writes win over the load port on A and X
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < `TRBMSA_NUM_NIB; i++) regs_r[i] <= `TRBMSA_NIB_RST;
    end else begin
      if (i_reg_wr) regs_r[i_reg_idx] <= i_reg_wdata;
      if (a_we) regs_r[`TRBMSA_IDX_A] <= a_wv;
      if (x_we) regs_r[`TRBMSA_IDX_X] <= x_wv;
    end
  end

  // carry flag and counter; a skipped op still advances the counter
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      carry_flag_r <= 1'b0;
      pc_r <= PC_W'(`TRBMSA_PC_RST);
    end else begin
      if (cy_we) carry_flag_r <= cy_val;
      else if (i_cy_wr) carry_flag_r <= i_cy_wdata;
      if (take) pc_r <= pc_adv;
      else if (i_pc_wr) pc_r <= i_pc_wdata;
    end
  end

  // skip and base-conversion state; conversion only reaches the very next op
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      skip_r <= 1'b0;
      conv_pend_r <= 1'b0;
      conv_skip_r <= 1'b0;
    end else if (take) begin
      skip_r <= eff_skip ? 1'b0 : skip_val;
      conv_pend_r <= 1'b0;
    end else if (dcap) begin
      skip_r <= (op_r == OP_SKIP_ADD_MEMORY) && sum_a_mem[4];
      conv_pend_r <= (op_r == OP_ADD_WITH_CARRY_MEMORY) ||
                     (op_r == OP_SUBTRACT_WITH_CARRY_MEMORY);
      conv_skip_r <= (op_r == OP_ADD_WITH_CARRY_MEMORY) ? sum_a_adc[4] : !dif_a_sbc[4];
    end
  end

  // completion pulses and write data
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      done_r <= 1'b0;
      skipped_r <= 1'b0;
      wdata_r <= 4'h0;
    end else begin
      done_r <= (take && (eff_skip || is_single)) || pcap || (state_r == ST_DWR) ||
                (dcap && (op_r != OP_BIT_MOVE_FROM_CARRY));
      skipped_r <= take && eff_skip;
      if (dcap) wdata_r <= bit_merged;
    end
  end

  // strobes are decoded from state; data and addresses come from flops
  assign o_op_ready = (state_r == ST_IDLE);
  assign o_op_done = done_r;
  assign o_op_skipped = skipped_r;
  assign o_skip_pending = skip_r;
  assign o_pc = pc_r;
  assign o_carry_flag = carry_flag_r;
  assign o_wide_accumulator_pair = pair_w[0];
  assign o_memory_pointer_pair = pair_w[1];
  assign o_pointer_pair_two = pair_w[2];
  assign o_general_pair_three = pair_w[3];
  assign o_pmem_rd = (state_r == ST_PREQ);
  assign o_pmem_addr = pmem_addr_r;
  assign o_dmem_rd = (state_r == ST_DREQ);
  assign o_dmem_wr = (state_r == ST_DWR);
  assign o_dmem_addr = dmem_addr_r;
  assign o_dmem_wdata = wdata_r;
endmodule // trbmsa_core

// ==== core/trbmsa_cfg.svh ====
// trbmsa_cfg.svh: offsets, field positions, reset values and widths for the
// table-read / bit-move / skip-add execution block.
// assumes: included by bare name from the package and the core module.
`ifndef TRBMSA_CFG_SVH
`define TRBMSA_CFG_SVH

// program counter width of the base parts (12 and 14 are the variants)
`define TRBMSA_PC_W 13
// data memory address width: 4-bit bank plus 8-bit bank-local address
`define TRBMSA_DA_W 12
`define TRBMSA_PC_RST 16'h0000
`define TRBMSA_NIB_RST 4'h0

// nibble register file slots; pair p is {slot 2p+1, slot 2p}
`define TRBMSA_IDX_A 4'h0
`define TRBMSA_IDX_X 4'h1
`define TRBMSA_IDX_L 4'h2
`define TRBMSA_IDX_H 4'h3
`define TRBMSA_IDX_E 4'h4
`define TRBMSA_IDX_D 4'h5
`define TRBMSA_IDX_C 4'h6
`define TRBMSA_IDX_B 4'h7
`define TRBMSA_NUM_NIB 16
`define TRBMSA_NUM_PAIR 8

// fixed bit-manipulation space sits in the top bank
`define TRBMSA_FIX_BANK 4'hF
`define TRBMSA_PAGE_LSB 8

`endif

// ==== core/trbmsa_pkg.sv ====
// trbmsa_pkg: operation, bit-addressing and sequencer types of the block.
// assumes: trbmsa_cfg.svh is on the include path.
package trbmsa_pkg;
  `include "trbmsa_cfg.svh"

  // operations the decoder hands over; OP_OTHER only advances the counter
  typedef enum logic [3:0] {
    OP_OTHER,
    OP_TABLE_READ_PAGE_PLUS_POINTER,
    OP_TABLE_READ_PAGE_PLUS_ACCUMULATOR,
    OP_TABLE_READ_REGISTER_ADDRESS_SHORT,
    OP_TABLE_READ_REGISTER_ADDRESS_LONG,
    OP_BIT_MOVE_TO_CARRY,
    OP_BIT_MOVE_FROM_CARRY,
    OP_SKIP_ADD_NIBBLE_IMM,
    OP_SKIP_ADD_BYTE_IMM,
    OP_SKIP_ADD_MEMORY,
    OP_SKIP_ADD_PAIR,
    OP_ADD_WITH_CARRY_MEMORY,
    OP_SUBTRACT_WITH_CARRY_MEMORY
  } trbmsa_op_e;

  // bit-manipulation addressing forms
  typedef enum logic [1:0] {
    BIT_FIXED_SPACE,
    BIT_PERIPHERAL_AT_LOW,
    BIT_HIGH_PLUS_OFFSET
  } trbmsa_bit_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREQ,
    ST_PCAP,
    ST_DREQ,
    ST_DCAP,
    ST_DWR
  } trbmsa_state_e;
endpackage

// ==== verif/trbmsa_core_asserts.sv ====
// trbmsa_core_asserts: port-level timing and value checks of the block.
// assumes: bound into trbmsa_core; a skipped op raises no memory strobe.
`timescale 1ns/10ps
module trbmsa_core_asserts
  import trbmsa_pkg::*;
#(
  parameter int PC_W = 13
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_op_valid,
  input wire logic o_op_ready,
  input wire trbmsa_pkg::trbmsa_op_e i_op,
  input wire logic [1:0] i_op_len,
  input wire logic [7:0] i_imm,
  input wire logic o_op_done,
  input wire logic o_op_skipped,
  input wire logic o_skip_pending,
  input wire logic [PC_W-1:0] o_pc,
  input wire logic [7:0] o_wide_accumulator_pair,
  input wire logic [7:0] o_pointer_pair_two,
  input wire logic o_pmem_rd,
  input wire logic [PC_W-1:0] o_pmem_addr,
  input wire logic [7:0] i_pmem_rdata
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // take edge, next counter value and a short alias
  wire take = i_op_valid && o_op_ready;
  wire [PC_W-1:0] pc_inc = o_pc + 1'b1;
  wire [7:0] wa = o_wide_accumulator_pair;
  logic conv_r;
  // last taken op was a carry add or subtract on memory
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      conv_r <= 1'b0;
    end else if (take) begin
      conv_r <= i_op inside {OP_ADD_WITH_CARRY_MEMORY, OP_SUBTRACT_WITH_CARRY_MEMORY};
    end
  end
  property p_page_ptr;
    take && i_op == OP_TABLE_READ_PAGE_PLUS_POINTER && !o_skip_pending |=>
      o_pmem_rd && o_pmem_addr == {$past(pc_inc[PC_W-1:8]), $past(o_pointer_pair_two)};
  endproperty
  a_page_ptr: assert property (p_page_ptr) else $error("pointer table address");
  property p_page_acc;
    take && i_op == OP_TABLE_READ_PAGE_PLUS_ACCUMULATOR && !o_skip_pending |=>
      o_pmem_rd && o_pmem_addr == {$past(pc_inc[PC_W-1:8]), $past(wa)};
  endproperty
  a_page_acc: assert property (p_page_acc) else $error("accumulator table address");
  property p_tbl_data;
    o_pmem_rd |=> ##1 o_op_done && wa == $past(i_pmem_rdata);
  endproperty
  a_tbl_data: assert property (p_tbl_data) else $error("table byte placement");
  property p_pc_step;
    take |=> o_pc == $past(o_pc) + PC_W'($past(i_op_len));
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("counter advance");
  property p_byte_add;
    take && i_op == OP_SKIP_ADD_BYTE_IMM && !o_skip_pending |=>
      {o_skip_pending, wa} == {1'b0, $past(wa)} + {1'b0, $past(i_imm)};
  endproperty
  a_byte_add: assert property (p_byte_add) else $error("byte skip add");
  property p_nib_add;
    take && i_op == OP_SKIP_ADD_NIBBLE_IMM && !o_skip_pending && !conv_r |=>
      {o_skip_pending, wa[3:0]} == {1'b0, $past(wa[3:0])} + {1'b0, $past(i_imm[3:0])};
  endproperty
  a_nib_add: assert property (p_nib_add) else $error("nibble skip add");
  property p_conv;
    take && i_op == OP_SKIP_ADD_NIBBLE_IMM && !o_skip_pending && conv_r |=>
      o_op_done && !o_skip_pending;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion skip not suppressed");
  property p_skipped;
    take && o_skip_pending |=> o_op_done && o_op_skipped && !o_skip_pending && $stable(wa);
  endproperty
  a_skipped: assert property (p_skipped) else $error("skipped op had effect");
endmodule // trbmsa_core_asserts

bind trbmsa_core trbmsa_core_asserts #(.PC_W(PC_W)) trbmsa_core_asserts_i (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_op_valid(i_op_valid),
  .o_op_ready(o_op_ready), .i_op(i_op), .i_op_len(i_op_len), .i_imm(i_imm),
  .o_op_done(o_op_done), .o_op_skipped(o_op_skipped), .o_skip_pending(o_skip_pending),
  .o_pc(o_pc), .o_wide_accumulator_pair(o_wide_accumulator_pair),
  .o_pointer_pair_two(o_pointer_pair_two), .o_pmem_rd(o_pmem_rd),
  .o_pmem_addr(o_pmem_addr), .i_pmem_rdata(i_pmem_rdata)
);

// ==== verif/trbmsa_mem.sv ====
// trbmsa_mem: program and data memory on the far side of the block.
// assumes: data is wanted only the cycle after a read strobe.
`timescale 1ns/10ps
module trbmsa_mem (
  input wire logic i_sys_clk,
  input wire logic i_pmem_rd,
  input wire logic [12:0] i_pmem_addr,
  output logic [7:0] o_pmem_rdata,
  input wire logic i_dmem_rd,
  input wire logic i_dmem_wr,
  input wire logic [11:0] i_dmem_addr,
  input wire logic [3:0] i_dmem_wdata,
  output logic [3:0] o_dmem_rdata
);
  logic [3:0] dm [4096] = '{default: 4'h5};
  // table byte mixes in the page so a wrong page gives other data
  function automatic logic [7:0] rom(input logic [12:0] a);
    return a[7:0] ^ {a[12:8], 3'h5};
  endfunction
  // answers one cycle, then toggles so stale data is never mistaken
  always @(posedge i_sys_clk) begin
    o_pmem_rdata <= i_pmem_rd ? rom(i_pmem_addr) : ~o_pmem_rdata;
    o_dmem_rdata <= i_dmem_rd ? dm[i_dmem_addr] : ~o_dmem_rdata;
    if (i_dmem_wr) begin
      dm[i_dmem_addr] <= i_dmem_wdata;
    end
  end
endmodule // trbmsa_mem

// ==== verif/tb_trbmsa_core.sv ====
// tb_trbmsa_core: directed runs of table reads, bit moves and skip adds.
// assumes: trbmsa_mem plays both memories; the checker is bound in.
`timescale 1ns/10ps
module tb_trbmsa_core;
  import trbmsa_pkg::*;
  logic clk = 1'h0, rst = 1'h1, v = 1'h0, rw = 1'h0, cw = 1'h0, cd = 1'h0, pw = 1'h0;
  logic [1:0] len = 2'h1, bs = 2'h1;
  logic [2:0] sel = 3'h5;
  logic [3:0] bk = 4'h2, ri = 4'h0, rd = 4'h0, dwd, ddat;
  logic [7:0] imm = 8'h00, ma = 8'h5D, xa, pdat;
  logic [11:0] da;
  logic [12:0] pd = 13'h0000, pc, pa;
  logic rdy, done, skd, skp, cy, prd, drd, dwr;
  trbmsa_op_e op = OP_OTHER;
  trbmsa_bit_mode_e bm = BIT_FIXED_SPACE;
  int bad_count = 0, comparisons = 0, cyc = 0;
  // clock, and a ceiling far above the run's hundred or so cycles
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end
  trbmsa_core trbmsa_core_i (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_op_valid(v), .o_op_ready(rdy), .i_op(op),
    .i_op_len(len), .i_imm(imm), .i_pair_sel(sel), .i_bit_mode(bm), .i_mem_addr(ma),
    .i_bit_sel(bs), .i_mem_bank(bk), .o_op_done(done), .o_op_skipped(skd),
    .o_skip_pending(skp), .i_reg_wr(rw), .i_reg_idx(ri), .i_reg_wdata(rd), .i_cy_wr(cw),
    .i_cy_wdata(cd), .i_pc_wr(pw), .i_pc_wdata(pd), .o_pc(pc), .o_carry_flag(cy),
    .o_wide_accumulator_pair(xa), .o_memory_pointer_pair(), .o_pointer_pair_two(),
    .o_general_pair_three(), .o_pmem_rd(prd), .o_pmem_addr(pa), .i_pmem_rdata(pdat),
    .o_dmem_rd(drd), .o_dmem_wr(dwr), .o_dmem_addr(da), .o_dmem_wdata(dwd),
    .i_dmem_rdata(ddat)
  );
  trbmsa_mem trbmsa_mem_i (
    .i_sys_clk(clk), .i_pmem_rd(prd), .i_pmem_addr(pa), .o_pmem_rdata(pdat),
    .i_dmem_rd(drd), .i_dmem_wr(dwr), .i_dmem_addr(da), .i_dmem_wdata(dwd),
    .o_dmem_rdata(ddat)
  );
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // one load cycle: w picks counter, carry or nibble slot
  task automatic ld(input [2:0] w, input [3:0] i, input [12:0] d);
    {pw, cw, rw, ri, rd, cd, pd} = {w, i, d[3:0], d[0], d};
    @(posedge clk) #1;
    {pw, cw, rw} = 3'h0;
  endtask
  // offer one op and wait for its done pulse
  task automatic run(input trbmsa_op_e o);
    op = o;
    v = 1'h1;
    @(posedge clk) #1 v = 1'h0;
    for (int n = 0; n < 8 && done !== 1'b1; n++) @(posedge clk) #1;
    chk("done", done, 1'h1);
  endtask
  task automatic t_table;
    logic [7:0] e;
    ld(3'h1, 4'h4, 13'h3);
    ld(3'h1, 4'h5, 13'hC);
    ld(3'h1, 4'h7, 13'hD);
    ld(3'h1, 4'h6, 13'h6);
    ld(3'h4, 4'h0, 13'h02FF);
    run(OP_TABLE_READ_PAGE_PLUS_POINTER);
    e = trbmsa_mem_i.rom(13'h03C3);
    chk("page_plus_pointer_mode", {pc, xa}, {13'h0300, e});
    run(OP_TABLE_READ_PAGE_PLUS_ACCUMULATOR);
    e = trbmsa_mem_i.rom({5'h03, e});
    chk("page_plus_accumulator_mode", xa, e);
    ld(3'h4, 4'h0, 13'h06FF);
    run(OP_TABLE_READ_PAGE_PLUS_ACCUMULATOR);
    e = trbmsa_mem_i.rom({5'h07, e});
    chk("page_plus_accumulator_mode_end", xa, e);
    run(OP_TABLE_READ_REGISTER_ADDRESS_SHORT);
    e = trbmsa_mem_i.rom({1'b1, 4'h6, e});
    chk("register_address_short_mode", xa, e);
    // upper bits of B fall off a 13-bit counter
    run(OP_TABLE_READ_REGISTER_ADDRESS_LONG);
    chk("register_address_long_mode", xa, trbmsa_mem_i.rom(13'h16C3));
  endtask
  task automatic t_bits;
    logic [11:0] ad [3] = '{12'hF5D, 12'hF5E, 12'h29D};
    logic [1:0] b [3] = '{2'h1, 2'h2, 2'h1};
    logic [3:0] pat = 4'hA;
    ld(3'h1, 4'h3, 13'h9);
    ld(3'h1, 4'h2, 13'hA);
    for (int m = 0; m < 3; m++) begin
      bm = trbmsa_bit_mode_e'(m);
      trbmsa_mem_i.dm[ad[m]] = pat;
      run(OP_BIT_MOVE_TO_CARRY);
      chk("to_carry", cy, pat[b[m]]);
      ld(3'h2, 4'h0, {12'h000, ~pat[b[m]]});
      run(OP_BIT_MOVE_FROM_CARRY);
      chk("from_carry", trbmsa_mem_i.dm[ad[m]], pat ^ (4'h1 << b[m]));
    end
  endtask
  // add that overflows, then a table read that must be skipped
  task automatic sk(input trbmsa_op_e o, input [7:0] x0, input [7:0] e);
    ld(3'h1, 4'h1, {9'h000, x0[7:4]});
    ld(3'h1, 4'h0, {9'h000, x0[3:0]});
    run(o);
    chk("sum", {skp, cy, xa}, {2'h3, e});
    run(OP_TABLE_READ_REGISTER_ADDRESS_LONG);
    chk("skipped", {skd, skp, xa}, {2'h2, e});
  endtask
  task automatic t_skips;
    ld(3'h2, 4'h0, 13'h1);
    trbmsa_mem_i.dm[12'h29A] = 4'h7;
    ld(3'h1, 4'hB, 13'h0);
    ld(3'h1, 4'hA, 13'h1);
    imm = 8'h08;
    sk(OP_SKIP_ADD_NIBBLE_IMM, 8'h09, 8'h01);
    imm = 8'h20;
    sk(OP_SKIP_ADD_BYTE_IMM, 8'hF0, 8'h10);
    sk(OP_SKIP_ADD_MEMORY, 8'h0C, 8'h03);
    sk(OP_SKIP_ADD_PAIR, 8'hFF, 8'h00);
  endtask
  // carry add or subtract on memory, then the nibble skip add
  task automatic t_base(input trbmsa_op_e o, input [3:0] a, input [3:0] ea, input s);
    ld(3'h2, 4'h0, 13'h0);
    ld(3'h1, 4'h0, {9'h000, a});
    run(o);
    imm = 8'h09;
    run(OP_SKIP_ADD_NIBBLE_IMM);
    chk("base", {skd, skp, xa[3:0]}, {s, 1'h0, ea});
  endtask
  task automatic results;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // reset for five cycles, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'h0;
    t_table();
    t_bits();
    t_skips();
    t_base(OP_ADD_WITH_CARRY_MEMORY, 4'h9, 4'h0, 1'h1);
    t_base(OP_ADD_WITH_CARRY_MEMORY, 4'h1, 4'h1, 1'h0);
    t_base(OP_SUBTRACT_WITH_CARRY_MEMORY, 4'h9, 4'h2, 1'h1);
    t_base(OP_SUBTRACT_WITH_CARRY_MEMORY, 4'h3, 4'h5, 1'h0);
    results();
  end
endmodule // tb_trbmsa_core
